//--- logic/bcfi_cfg.svh
// What this block does
// RQ1: Overvoltage ends charging, sets status bit 15 and the overvoltage event.
// RQ2: Defective when fast threshold unmet within longer of fixed timeout and quarter charge timeout.
// RQ3: Failure clears on voltage above defective threshold or source reconnect; charger restarts.
// RQ4: Failure in fast charge falls back to trickle; persisting fault stops trickle.
// RQ5: Battery failure ends charging and sets event bit 13.
// RQ6: Hot status bit 11, cold status bit 10, live while condition holds.
// RQ7: Temperature fault pauses charging and sets hot event 15 or cold event 14.
// RQ8: Unconnected thermistor suppresses hot and cold indications.
// RQ9: Thermistor reports battery removal; removal during charging ends charging.
// RQ10: Monitor-disable strap sampled only at start-up, never in ON or SLEEP.
// RQ11: Every event feeds the charger interrupt unless its mask bit is set.
// RQ12: Any event while in SLEEP requests WAKE, ignoring masks.
// RQ13: SLEEP request with any event flag set is rejected; stay ON.
// RQ14: Charge start in SLEEP raises an event that moves the device to ON.
// RQ15: Software clears the charge-start flag before commanding SLEEP to keep charging.
// RQ16: Mode-change bit 9 and charge-start bit 8 set on rising edge, write-one clears.
// RQ17: End-of-charge bit 11 sets on rising edge, write-one clears.
// RQ18: Charge-timeout bit 10 sets on rising edge, write-one clears.
// RQ19: Each event has a mask at the same bit; masks reset to one.
// RQ20: Status bits 14:12 show charger state; defective reads 101.
// RQ21: Interrupt is OR of unmasked flags, held until software clears them.
`ifndef BCFI_CFG_SVH
`define BCFI_CFG_SVH

`define BCFI_OFS_FLAGS 16'h4012
`define BCFI_OFS_MASKS 16'h401a
`define BCFI_OFS_STATUS 16'h404a

`define BCFI_EVT_LSB 8
`define BCFI_EV_HOT 7
`define BCFI_EV_COLD 6
`define BCFI_EV_FAIL 5
`define BCFI_EV_OV 4
`define BCFI_EV_END 3
`define BCFI_EV_TO 2
`define BCFI_EV_MODE 1
`define BCFI_EV_START 0

`define BCFI_ST_OV 15
`define BCFI_ST_STATE_LSB 12
`define BCFI_ST_HOT 11
`define BCFI_ST_COLD 10

`define BCFI_MASK_RST 8'hff
`define BCFI_MONEN_RST 1'h1

`define BCFI_CLK_HZ 40000000
`define BCFI_TICK_S 30
`define BCFI_DEF_TMO_HM 9'h05a
`define BCFI_QTR_BASE_HM 9'h01e
`define BCFI_QTR_STEP_HM 9'h00f

`endif

//--- logic/bcfi_pkg.sv
package bcfi_pkg;

  typedef enum logic [2:0] {
    CS_OFF = 3'h0,
    CS_TRICKLE = 3'h1,
    CS_FAST = 3'h2,
    CS_TRICKLE_OT = 3'h3,
    CS_FAST_OT = 3'h4,
    CS_DEFECTIVE = 3'h5
  } bcfi_state_t;

  typedef struct packed {
    logic ov;
    logic aboveFast;
    logic aboveDef;
    logic hot;
    logic cold;
    logic ntcOpen;
    logic removed;
    logic strap;
    logic srcPresent;
  } bcfi_pins_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bcfi_bus_t;

  typedef struct packed {
    bcfi_pins_t sync1;
    bcfi_pins_t sync2;
    logic [30:0] divCnt;
    logic tick;
    logic tempMonEn;
    bcfi_state_t state;
    logic [8:0] defCnt;
    logic prevDef;
    logic prevSrc;
    logic [7:0] condPrev;
    logic [7:0] flags;
    logic [7:0] masks;
    logic [15:0] rdData;
    logic irq;
    logic wake;
    logic sleepRej;
    logic sleepAcc;
    logic trickleOn;
    logic fastOn;
  } bcfi_regs_t;

endpackage

//--- logic/bcfi_top.sv
`timescale 1ns/1ps
`include "bcfi_cfg.svh"

module bcfi_top #(
  parameter int unsigned TICK_CYCLES = `BCFI_TICK_S * `BCFI_CLK_HZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire bcfi_pkg::bcfi_pins_t pinsIn,
  input wire bcfi_pkg::bcfi_bus_t bus,
  output logic [15:0] rdData,
  input wire logic chgEnable,
  input wire logic eocReached,
  input wire logic timerExpired,
  input wire logic [3:0] timeoutSetting,
  input wire logic [7:0] elapsedTime,
  input wire logic startupActive,
  input wire logic inSleep,
  input wire logic sleepReq,
  output logic chgIrq,
  output logic wakeReq,
  output logic sleepReject,
  output logic sleepAccept,
  output logic trickleOn,
  output logic fastOn
);

  // ***********************************************
  // Helpers
  // ***********************************************
  function automatic logic isCharging(input bcfi_pkg::bcfi_state_t s);
    isCharging = (s == bcfi_pkg::CS_TRICKLE) || (s == bcfi_pkg::CS_FAST) ||
                 (s == bcfi_pkg::CS_TRICKLE_OT) || (s == bcfi_pkg::CS_FAST_OT);
  endfunction

  function automatic logic isActive(input bcfi_pkg::bcfi_state_t s);
    isActive = (s == bcfi_pkg::CS_TRICKLE) || (s == bcfi_pkg::CS_FAST);
  endfunction

  function automatic logic regHit(input logic [15:0] a, input logic [15:0] ofs);
    regHit = (a == ofs);
  endfunction

  // ***********************************************
  // State
  // ***********************************************
  bcfi_pkg::bcfi_regs_t q;
  bcfi_pkg::bcfi_regs_t d;
  bcfi_pkg::bcfi_pins_t pins;
  logic [30:0] tickLast;
  logic [8:0] quarterHm;
  logic [8:0] defLimit;
  logic defExpire;
  logic hotNow;
  logic coldNow;
  logic removedNow;
  logic tempFault;
  logic terminate;
  logic failClear;
  logic modeChg;
  logic [7:0] cond;
  logic [7:0] evSet;
  logic [7:0] evClr;
  logic [15:0] statusWord;

  assign pins = q.sync2;
  assign tickLast = 31'(TICK_CYCLES - 1);

  // Quarter of the charge timeout, in half-minute ticks
  assign quarterHm = `BCFI_QTR_BASE_HM + `BCFI_QTR_STEP_HM * {5'h00, timeoutSetting};
  assign defLimit = (quarterHm > `BCFI_DEF_TMO_HM) ? quarterHm : `BCFI_DEF_TMO_HM; // RQ2
  assign defExpire = (q.defCnt >= defLimit); // RQ2

  // ***********************************************
  // Next state
  // ***********************************************
  always_comb begin
    d = q;
    // Two-stage synchroniser on the analog comparator levels
    d.sync1 = pinsIn;
    d.sync2 = q.sync1;

    // Half-minute enable for the defective timer
    d.tick = (q.divCnt == tickLast);
    if (q.divCnt == tickLast) begin
      d.divCnt = 31'h0000_0000;
    end else begin
      d.divCnt = q.divCnt + 31'h0000_0001;
    end

    // Strap only looked at while start-up runs
    if (startupActive) begin
      d.tempMonEn = ~pins.strap; // RQ10
    end

    // Open thermistor would look like a huge temperature swing; hide it
    hotNow = q.tempMonEn & ~pins.ntcOpen & pins.hot; // RQ8
    coldNow = q.tempMonEn & ~pins.ntcOpen & pins.cold; // RQ8
    removedNow = q.tempMonEn & pins.removed; // RQ9
    tempFault = hotNow | coldNow;
    terminate = pins.ov | removedNow | eocReached | timerExpired | ~chgEnable; // RQ1 RQ9
    failClear = (pins.aboveDef & ~q.prevDef) | (pins.srcPresent & ~q.prevSrc); // RQ3
    d.prevDef = pins.aboveDef;
    d.prevSrc = pins.srcPresent;

    unique case (q.state)
      bcfi_pkg::CS_OFF: begin
        if (!terminate) begin
          if (tempFault) begin
            d.state = bcfi_pkg::CS_TRICKLE_OT;
          end else if (pins.aboveFast) begin
            d.state = bcfi_pkg::CS_FAST;
          end else begin
            d.state = bcfi_pkg::CS_TRICKLE;
          end
        end
      end
      bcfi_pkg::CS_TRICKLE: begin
        if (terminate) begin
          d.state = bcfi_pkg::CS_OFF; // RQ1
        end else if (tempFault) begin
          d.state = bcfi_pkg::CS_TRICKLE_OT; // RQ7
        end else if (defExpire) begin
          d.state = bcfi_pkg::CS_DEFECTIVE; // RQ2 RQ4 RQ5
        end else if (pins.aboveFast) begin
          d.state = bcfi_pkg::CS_FAST;
        end
      end
      bcfi_pkg::CS_FAST: begin
        if (terminate) begin
          d.state = bcfi_pkg::CS_OFF; // RQ1
        end else if (tempFault) begin
          d.state = bcfi_pkg::CS_FAST_OT; // RQ7
        end else if (!pins.aboveFast) begin
          d.state = bcfi_pkg::CS_TRICKLE; // RQ4
        end
      end
      bcfi_pkg::CS_TRICKLE_OT: begin
        if (terminate) begin
          d.state = bcfi_pkg::CS_OFF;
        end else if (!tempFault) begin
          d.state = bcfi_pkg::CS_TRICKLE;
        end
      end
      bcfi_pkg::CS_FAST_OT: begin
        if (terminate) begin
          d.state = bcfi_pkg::CS_OFF;
        end else if (!tempFault) begin
          d.state = bcfi_pkg::CS_FAST;
        end
      end
      bcfi_pkg::CS_DEFECTIVE: begin
        if (failClear) begin
          d.state = bcfi_pkg::CS_OFF; // RQ3
        end
      end
      default: begin
        d.state = bcfi_pkg::CS_OFF;
      end
    endcase

    // Defective timer: restarts on trickle entry straight from off or fast, holds while paused (also after an off-to-paused start)
    if ((d.state == bcfi_pkg::CS_TRICKLE) && (q.state != bcfi_pkg::CS_TRICKLE) &&
        (q.state != bcfi_pkg::CS_TRICKLE_OT)) begin
      d.defCnt = 9'h000; // RQ4
    end else if ((q.state == bcfi_pkg::CS_TRICKLE) && q.tick && !defExpire) begin
      d.defCnt = q.defCnt + 9'h001; // RQ2
    end

    // ***********************************************
    // Events
    // ***********************************************
    modeChg = isActive(q.state) & isActive(d.state) & (q.state != d.state);
    cond = 8'h00;
    cond[`BCFI_EV_HOT] = hotNow; // RQ7
    cond[`BCFI_EV_COLD] = coldNow; // RQ7
    cond[`BCFI_EV_FAIL] = (d.state == bcfi_pkg::CS_DEFECTIVE); // RQ5
    cond[`BCFI_EV_OV] = pins.ov; // RQ1
    cond[`BCFI_EV_END] = eocReached; // RQ17
    cond[`BCFI_EV_TO] = timerExpired; // RQ18
    cond[`BCFI_EV_MODE] = modeChg; // RQ16
    cond[`BCFI_EV_START] = isCharging(d.state); // RQ16 RQ14
    d.condPrev = cond;
    evSet = cond & ~q.condPrev;

    evClr = 8'h00;
    if (bus.wr && regHit(bus.addr, `BCFI_OFS_FLAGS)) begin
      evClr = bus.wdata[15:`BCFI_EVT_LSB];
    end
    // Set beats clear so no event is dropped
    d.flags = (q.flags & ~evClr) | evSet; // RQ16 RQ17 RQ18

    if (bus.wr && regHit(bus.addr, `BCFI_OFS_MASKS)) begin
      d.masks = bus.wdata[15:`BCFI_EVT_LSB]; // RQ19
    end

    d.irq = |(d.flags & ~d.masks); // RQ11 RQ21
    d.wake = inSleep & (|evSet); // RQ12 RQ14
    d.sleepRej = sleepReq & (|(q.flags | evSet)); // RQ13
    d.sleepAcc = sleepReq & ~(|(q.flags | evSet)); // RQ13

    // ***********************************************
    // Read port
    // ***********************************************
    statusWord = 16'h0000;
    statusWord[`BCFI_ST_OV] = pins.ov; // RQ1
    statusWord[`BCFI_ST_STATE_LSB +: 3] = q.state; // RQ20
    statusWord[`BCFI_ST_HOT] = hotNow; // RQ6
    statusWord[`BCFI_ST_COLD] = coldNow; // RQ6
    statusWord[7:0] = elapsedTime;

    d.rdData = 16'h0000;
    if (bus.rd) begin
      if (regHit(bus.addr, `BCFI_OFS_FLAGS)) begin
        d.rdData = {q.flags, 8'h00};
      end else if (regHit(bus.addr, `BCFI_OFS_MASKS)) begin
        d.rdData = {q.masks, 8'h00};
      end else if (regHit(bus.addr, `BCFI_OFS_STATUS)) begin
        d.rdData = statusWord;
      end
    end

    d.trickleOn = (d.state == bcfi_pkg::CS_TRICKLE);
    d.fastOn = (d.state == bcfi_pkg::CS_FAST);
  end

  // ***********************************************
  // Registers
  // ***********************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.masks <= `BCFI_MASK_RST; // RQ19
      q.tempMonEn <= `BCFI_MONEN_RST;
    end else begin
      q <= d;
    end
  end

  assign rdData = q.rdData;
  assign chgIrq = q.irq;
  assign wakeReq = q.wake;
  assign sleepReject = q.sleepRej;
  assign sleepAccept = q.sleepAcc;
  assign trickleOn = q.trickleOn;
  assign fastOn = q.fastOn;

endmodule

//--- sim/bcfi_properties.sv
`timescale 1ns/1ps
// ****************
// Port-level checks
// ****************
module bcfi_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire bcfi_pkg::bcfi_pins_t pinsIn,
  input wire bcfi_pkg::bcfi_bus_t bus,
  input wire logic [15:0] rdData,
  input wire logic eocReached,
  input wire logic inSleep,
  input wire logic sleepReq,
  input wire logic chgIrq,
  input wire logic wakeReq,
  input wire logic sleepReject,
  input wire logic sleepAccept,
  input wire logic trickleOn,
  input wire logic fastOn
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Five cycles covers the two sync flops and the state register
  sequence ovHeld;
    pinsIn.ov [*5];
  endsequence
  sequence eocRise;
    !eocReached ##1 eocReached;
  endsequence
  a_ov_stops: assert property (ovHeld |-> !trickleOn && !fastOn)
    else $error("charging under overvoltage");
  a_eoc_wakes: assert property (eocRise ##0 inSleep |=> wakeReq)
    else $error("no wake after event");
  a_wake_cause: assert property (wakeReq |-> $past(inSleep))
    else $error("wake outside sleep");
  a_irq_held: assert property ($fell(chgIrq) |-> $past(bus.wr))
    else $error("irq dropped without write");
  a_sleep_answer: assert property (sleepReq |=> sleepAccept != sleepReject)
    else $error("bad sleep answer");
  a_sleep_cause: assert property (sleepAccept || sleepReject |-> $past(sleepReq))
    else $error("sleep answer unasked");
  a_rd_window: assert property (rdData != 16'h0000 |-> $past(bus.rd))
    else $error("read data outside window");
  a_mode_excl: assert property (!(trickleOn && fastOn))
    else $error("trickle and fast together");
endmodule
bind bcfi_top bcfi_properties i_bcfi_properties (.clk, .rst_n, .pinsIn, .bus, .rdData, .eocReached,
  .inSleep, .sleepReq, .chgIrq, .wakeReq, .sleepReject, .sleepAccept, .trickleOn, .fastOn);

//--- sim/bcfi_pack_model.sv
`timescale 1ns/1ps
// ****************
// Battery pack
// ****************
module bcfi_pack_model (
  input wire logic clk,
  input wire logic [1:0] vLevel,
  input wire logic [1:0] temp,
  output bcfi_pkg::bcfi_pins_t pins
);
  // An open thermistor also trips the cold comparator, as a real pack would
  always_ff @(posedge clk) begin
    pins.ov <= vLevel == 2'h3;
    pins.aboveFast <= vLevel >= 2'h2;
    pins.aboveDef <= vLevel >= 2'h1;
    pins.hot <= temp == 2'h1;
    pins.cold <= temp >= 2'h2;
    pins.ntcOpen <= temp == 2'h3;
    pins.removed <= 1'h0;
    pins.strap <= 1'h0;
    pins.srcPresent <= 1'h1;
  end
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module testbench;
  typedef struct packed {logic [15:0] mask; logic [1:0] kick; logic [15:0] flags; logic irq;} bcfi_row_t;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  bcfi_pkg::bcfi_pins_t pinsIn;
  bcfi_pkg::bcfi_bus_t bus = '0;
  logic [15:0] rdData, d;
  logic chgEnable = 1'h0, eocReached = 1'h0, timerExpired = 1'h0, startupActive = 1'h1;
  logic inSleep = 1'h0, sleepReq = 1'h0;
  logic [3:0] timeoutSetting = 4'h0;
  logic [1:0] vLevel = 2'h2, temp = 2'h0;
  logic chgIrq, wakeReq, sleepReject, sleepAccept, trickleOn, fastOn;
  int num_errors = 0, compares = 0, cycles = 0;
  bcfi_row_t rows [4] = '{'{16'hffff, 2'h2, 16'h0800, 1'h0}, '{16'hf7ff, 2'h2, 16'h0800, 1'h1},
    '{16'hfbff, 2'h1, 16'h0400, 1'h1}, '{16'h0000, 2'h3, 16'h0c00, 1'h1}};
  logic [1:0] tCode [3] = '{2'h1, 2'h3, 2'h2};
  logic [15:0] tSt [3] = '{16'h085a, 16'h005a, 16'h045a};
  logic [15:0] tFl [3] = '{16'h8000, 16'h0000, 16'h4000};
  bcfi_pack_model i_bcfi_pack_model (.clk, .vLevel, .temp, .pins(pinsIn));
  bcfi_top #(.TICK_CYCLES(4)) i_bcfi_top (.clk, .rst_n, .pinsIn, .bus, .rdData, .chgEnable, .eocReached,
    .timerExpired, .timeoutSetting, .elapsedTime(8'h5a), .startupActive, .inSleep, .sleepReq, .chgIrq,
    .wakeReq, .sleepReject, .sleepAccept, .trickleOn, .fastOn);
  always #12.5 clk = ~clk;
  task stop_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Whole run needs under 2000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    bus <= '{a, v, 1'h1, 1'h0};
    @(posedge clk);
    bus.wr <= 1'h0;
  endtask
  task rd(input logic [15:0] a);
    @(posedge clk);
    bus <= '{a, 16'h0000, 1'h0, 1'h1};
    @(posedge clk);
    bus.rd <= 1'h0;
    #1;
    d = rdData;
  endtask
  task sleepTry(input logic [15:0] exp);
    @(posedge clk);
    sleepReq <= 1'h1;
    @(posedge clk);
    sleepReq <= 1'h0;
    #1;
    chk({14'h0000, sleepReject, sleepAccept}, exp);
  endtask
  initial begin
    cyc(6);
    rst_n <= 1'h1;
    cyc(3);
    startupActive <= 1'h0;
    rd(16'h401a);
    chk(d, 16'hff00);
    wr(16'h404a, 16'hffff);
    rd(16'h404a);
    chk(d, 16'h005a);
    rd(16'h4000);
    chk(d, 16'h0000);
    foreach (rows[i]) begin
      wr(16'h401a, rows[i].mask);
      @(posedge clk);
      {eocReached, timerExpired} <= rows[i].kick;
      cyc(3);
      {eocReached, timerExpired} <= 2'h0;
      rd(16'h4012);
      chk(d, rows[i].flags);
      chk({15'h0000, chgIrq}, {15'h0000, rows[i].irq});
      wr(16'h4012, 16'hff00);
      rd(16'h4012);
      chk({d[15:1], chgIrq}, 16'h0000);
    end
    foreach (tCode[i]) begin
      @(posedge clk);
      temp <= tCode[i];
      cyc(6);
      rd(16'h404a);
      chk(d, tSt[i]);
      rd(16'h4012);
      chk(d, tFl[i]);
      sleepTry(i == 1 ? 16'h0001 : 16'h0002);
      @(posedge clk);
      temp <= 2'h0;
      cyc(6);
      wr(16'h4012, 16'hff00);
    end
    wr(16'h401a, 16'hffff);
    @(posedge clk);
    inSleep <= 1'h1;
    eocReached <= 1'h1;
    @(posedge clk);
    #1;
    chk({15'h0000, wakeReq}, 16'h0001);
    @(posedge clk);
    eocReached <= 1'h0;
    inSleep <= 1'h0;
    vLevel <= 2'h0;
    wr(16'h4012, 16'hff00);
    // Low level must clear pack flop and sync flops, else start goes fast first
    cyc(4);
    timeoutSetting <= 4'hf;
    chgEnable <= 1'h1;
    cyc(950);
    chk({15'h0000, trickleOn}, 16'h0001);
    cyc(200);
    rd(16'h404a);
    chk(d, 16'h505a);
    chk({15'h0000, trickleOn}, 16'h0000);
    rd(16'h4012);
    chk(d, 16'h2100);
    wr(16'h4012, 16'hff00);
    vLevel <= 2'h1;
    cyc(10);
    chk({15'h0000, trickleOn}, 16'h0001);
    wr(16'h4012, 16'hff00);
    vLevel <= 2'h2;
    cyc(8);
    rd(16'h4012);
    chk(d & 16'h0300, 16'h0200);
    vLevel <= 2'h3;
    cyc(8);
    rd(16'h404a);
    chk(d & 16'h8000, 16'h8000);
    rd(16'h4012);
    chk(d & 16'h1000, 16'h1000);
    stop_test();
  end
endmodule
